// file: utxq_dma.sv
// utxq_dma.sv: transmit descriptor queue dma engine feeding usb endpoints
// Summary of operation
// RULE1 - each channel keeps head, completion, sop, current, buffer and length state
// RULE2 - one queue per channel with one head and one completion pointer
// RULE3 - software appends at tail; engine releases packets from the head
// RULE4 - software zeroes the channel state words after reset before use
// RULE5 - software builds queue, enables endpoint dma, port dma, then writes head
// RULE6 - writing a nonzero head pointer starts transmission on that channel
// RULE7 - next pointer word aligned or zero, buffer pointer byte aligned
// RULE8 - buffer length is byte count; nonzero offset only in first buffer
// RULE9 - software clears queue end and sets first, last, owner flags properly
// RULE10 - first descriptor of each packet has first-buffer and owner flags set
// RULE11 - engine keeps sending packets until the queue is empty
// RULE12 - on packet end clear owner, then write last descriptor to completion
// RULE13 - on queue end set queue end, clear owner, zero head, write completion
// RULE14 - one channel interrupt per transmitted packet
// RULE15 - software acknowledges by writing last descriptor back to completion
// RULE16 - interrupt holds while software value differs from engine value
// RULE17 - software reclaims packets with owner cleared, stops at owned or end
// RULE18 - queue fully sent: owner clear, queue end set, next pointer zero
// RULE19 - queue end with nonzero next pointer means a missed append
// RULE20 - software recovers missed append by writing its first descriptor to head
// RULE21 - word 3 bit 29 owner flag, 1 engine 0 processor, first buffer only
// RULE22 - word 3 bits 31 first, 30 last, 28 queue end when last set
// RULE23 - 16-bit packet length truncates data when below buffer sum
`include "utxq_map.svh"

module utxq_dma
  import utxq_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int FIFO_DEPTH = `UTXQ_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dma_port_enable,
  input wire logic [NUM_CH-1:0] endpoint_dma_enable,
  input wire logic sw_wr,
  input wire logic [$clog2(NUM_CH)-1:0] sw_ch,
  input wire logic [2:0] sw_sel,
  input wire logic [31:0] sw_data,
  input wire logic [$clog2(NUM_CH)-1:0] view_ch,
  output logic [31:0] tx_queue_head_ptr,
  output logic [31:0] tx_sop_descriptor_ptr,
  output logic [31:0] tx_current_descriptor_ptr,
  output logic [31:0] tx_current_buffer_ptr,
  output logic [31:0] tx_scratch_word,
  output logic [31:0] tx_packet_length_state,
  output logic [31:0] tx_completion_ptr,
  output logic [NUM_CH-1:0] tx_irq,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic ep_valid,
  input wire logic ep_ready,
  output logic [7:0] ep_data,
  output logic ep_last,
  output logic [$clog2(NUM_CH)-1:0] ep_ch
);

  localparam int CHW = $clog2(NUM_CH);
  localparam int FW = 9 + CHW;
  initial begin
    if (NUM_CH < 2 || NUM_CH > 16) begin
      $error("utxq_dma: NUM_CH must lie between 2 and 16");
    end
  end
  // ************************************************************
  // per-channel state
  // ************************************************************
  logic [31:0] head_reg [NUM_CH];
  logic [31:0] sop_reg [NUM_CH];
  logic [31:0] cur_reg [NUM_CH];
  logic [31:0] buf_reg [NUM_CH];
  logic [31:0] scr_reg [NUM_CH];
  logic [15:0] rem_reg [NUM_CH];
  logic [15:0] act_reg [NUM_CH];
  logic [31:0] comp_reg [NUM_CH];
  logic [NUM_CH-1:0] pend_reg;
  // ************************************************************
  // working registers of the sequencer
  // ************************************************************
  utxq_state_t state_reg;
  logic [CHW-1:0] ch_reg;
  logic [CHW-1:0] scan_reg;
  logic [31:0] nxt_reg;
  logic [31:0] bptr_reg;
  logic [15:0] boff_reg;
  logic [15:0] bcnt_reg;
  logic [31:0] flags_reg;
  logic [7:0] byte_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic we_reg;
  logic comp_set;
  logic push;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_out;
  // byte lane picked out of a little-endian word
  function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] a);
    lane_byte = w[{a, 3'b000} +: 8];
  endfunction : lane_byte
  // byte address of a descriptor field word
  function automatic logic [31:0] fld(input logic [31:0] d, input logic [31:0] ofs);
    fld = d + ofs;
  endfunction : fld
  // ************************************************************
  // memory master: request held until acknowledged
  // ************************************************************
  assign mem_req = state_reg inside {UTXQ_RD_NEXT, UTXQ_RD_BUF, UTXQ_RD_LEN, UTXQ_RD_FLAGS,
                   UTXQ_RD_BYTE, UTXQ_WR_EOQ, UTXQ_WR_OWN};
  assign mem_we = we_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  // byte push into the endpoint fifo; stalls the sequencer while full
  assign push = (state_reg == UTXQ_PUSH) && fifo_in_ready;
  assign comp_set = (state_reg == UTXQ_COMP);
  // ************************************************************
  // sequencer: one packet per visit, channels scanned in turn
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= UTXQ_IDLE;
      ch_reg <= '0;
      scan_reg <= '0;
      nxt_reg <= `UTXQ_PTR_RST;
      bptr_reg <= `UTXQ_PTR_RST;
      boff_reg <= '0;
      bcnt_reg <= '0;
      flags_reg <= '0;
      byte_reg <= '0;
      addr_reg <= `UTXQ_PTR_RST;
      wdata_reg <= '0;
      we_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        head_reg[i] <= `UTXQ_PTR_RST;
        sop_reg[i] <= `UTXQ_PTR_RST;
        cur_reg[i] <= `UTXQ_PTR_RST;
        buf_reg[i] <= `UTXQ_PTR_RST;
        scr_reg[i] <= `UTXQ_PTR_RST;
        rem_reg[i] <= '0;
        act_reg[i] <= '0;
      end
    end else begin
      case (state_reg)
        UTXQ_IDLE: begin
          // a nonzero head on an enabled channel starts the next packet
          if (dma_port_enable && endpoint_dma_enable[scan_reg] &&
              head_reg[scan_reg] != `UTXQ_PTR_RST) begin // RULE6 RULE11
            ch_reg <= scan_reg;
            cur_reg[scan_reg] <= head_reg[scan_reg]; // RULE3
            addr_reg <= fld(head_reg[scan_reg], `UTXQ_DESC_NEXT_OFS);
            we_reg <= 1'b0;
            state_reg <= UTXQ_RD_NEXT;
          end
          scan_reg <= (scan_reg == CHW'(NUM_CH - 1)) ? '0 : scan_reg + 1'b1;
        end
        UTXQ_RD_NEXT: begin
          if (mem_ack) begin
            nxt_reg <= mem_rdata;
            addr_reg <= fld(cur_reg[ch_reg], `UTXQ_DESC_BUF_OFS);
            state_reg <= UTXQ_RD_BUF;
          end
        end
        UTXQ_RD_BUF: begin
          if (mem_ack) begin
            bptr_reg <= mem_rdata;
            addr_reg <= fld(cur_reg[ch_reg], `UTXQ_DESC_LEN_OFS);
            state_reg <= UTXQ_RD_LEN;
          end
        end
        UTXQ_RD_LEN: begin
          if (mem_ack) begin
            boff_reg <= mem_rdata[31:`UTXQ_OFS_LSB];
            bcnt_reg <= mem_rdata[`UTXQ_LEN_MSB:0];
            addr_reg <= fld(cur_reg[ch_reg], `UTXQ_DESC_FLAGS_OFS);
            state_reg <= UTXQ_RD_FLAGS;
          end
        end
        UTXQ_RD_FLAGS: begin
          if (mem_ack) begin
            flags_reg <= mem_rdata;
            if (mem_rdata[`UTXQ_FIRST_BUF_BIT]) begin // RULE22
              // first buffer: packet length and offset apply only here
              sop_reg[ch_reg] <= cur_reg[ch_reg];
              scr_reg[ch_reg] <= mem_rdata;
              rem_reg[ch_reg] <= mem_rdata[`UTXQ_ZERO_BYTE_BIT] ? 16'h0000 :
                                 mem_rdata[`UTXQ_LEN_MSB:0]; // RULE23
              act_reg[ch_reg] <= 16'h0000;
              buf_reg[ch_reg] <= bptr_reg + {16'h0000, boff_reg};
            end else begin
              buf_reg[ch_reg] <= bptr_reg;
            end
            state_reg <= UTXQ_CHK;
          end
        end
        UTXQ_CHK: begin
          if (bcnt_reg != 16'h0000 && rem_reg[ch_reg] != 16'h0000) begin
            addr_reg <= {buf_reg[ch_reg][31:2], 2'b00};
            state_reg <= UTXQ_RD_BYTE;
          end else if (flags_reg[`UTXQ_LAST_BUF_BIT] || nxt_reg == `UTXQ_PTR_RST) begin
            // packet done; a zero next pointer also ends a malformed packet
            we_reg <= 1'b1;
            if (nxt_reg == `UTXQ_PTR_RST) begin
              addr_reg <= fld(cur_reg[ch_reg], `UTXQ_DESC_FLAGS_OFS);
              wdata_reg <= flags_reg | (32'h0000_0001 << `UTXQ_QUEUE_END_BIT); // RULE13
              state_reg <= UTXQ_WR_EOQ;
            end else begin
              addr_reg <= fld(sop_reg[ch_reg], `UTXQ_DESC_FLAGS_OFS);
              wdata_reg <= scr_reg[ch_reg] & ~(32'h0000_0001 << `UTXQ_OWN_BIT); // RULE12
              state_reg <= UTXQ_WR_OWN;
            end
          end else begin
            // mid-packet: follow the link; descriptors past a truncation are walked, their bytes not read or sent
            cur_reg[ch_reg] <= nxt_reg;
            addr_reg <= fld(nxt_reg, `UTXQ_DESC_NEXT_OFS);
            state_reg <= UTXQ_RD_NEXT;
          end
        end
        UTXQ_RD_BYTE: begin
          // one word read per byte: simple, costs bus bandwidth
          if (mem_ack) begin
            byte_reg <= lane_byte(mem_rdata, buf_reg[ch_reg][1:0]);
            state_reg <= UTXQ_PUSH;
          end
        end
        UTXQ_PUSH: begin
          if (push) begin
            buf_reg[ch_reg] <= buf_reg[ch_reg] + 32'h0000_0001;
            bcnt_reg <= bcnt_reg - 16'h0001;
            rem_reg[ch_reg] <= rem_reg[ch_reg] - 16'h0001; // RULE23
            act_reg[ch_reg] <= act_reg[ch_reg] + 16'h0001;
            state_reg <= UTXQ_CHK;
          end
        end
        UTXQ_WR_EOQ: begin
          if (mem_ack) begin
            addr_reg <= fld(sop_reg[ch_reg], `UTXQ_DESC_FLAGS_OFS);
            // one-buffer packet: keep the queue end bit that was just written
            wdata_reg <= ((sop_reg[ch_reg] == cur_reg[ch_reg]) ? wdata_reg : scr_reg[ch_reg]) &
                         ~(32'h0000_0001 << `UTXQ_OWN_BIT); // RULE13 RULE21
            state_reg <= UTXQ_WR_OWN;
          end
        end
        UTXQ_WR_OWN: begin
          if (mem_ack) begin
            we_reg <= 1'b0;
            head_reg[ch_reg] <= nxt_reg; // RULE3 RULE13
            state_reg <= UTXQ_COMP;
          end
        end
        UTXQ_COMP: begin
          state_reg <= UTXQ_IDLE; // RULE14
        end
        default: begin
          state_reg <= UTXQ_IDLE;
        end
      endcase
      // software state writes land last and so take precedence
      if (sw_wr) begin // RULE1 RULE2
        case (sw_sel)
          `UTXQ_SEL_HEAD: head_reg[sw_ch] <= sw_data; // RULE6 RULE20
          `UTXQ_SEL_SOP: sop_reg[sw_ch] <= sw_data;
          `UTXQ_SEL_CUR: cur_reg[sw_ch] <= sw_data;
          `UTXQ_SEL_BUF: buf_reg[sw_ch] <= sw_data;
          `UTXQ_SEL_SCRATCH: scr_reg[sw_ch] <= sw_data;
          `UTXQ_SEL_LEN: begin
            rem_reg[sw_ch] <= sw_data[31:16];
            act_reg[sw_ch] <= sw_data[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // completion pointer and channel interrupt
  // ************************************************************
  // engine write sets the interrupt; a matching software write clears it,
  // and an engine write in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        comp_reg[i] <= `UTXQ_PTR_RST;
      end
    end else begin
      if (sw_wr && sw_sel == `UTXQ_SEL_COMP && sw_data == comp_reg[sw_ch]) begin // RULE15
        pend_reg[sw_ch] <= 1'b0; // RULE16
      end
      if (comp_set) begin
        comp_reg[ch_reg] <= cur_reg[ch_reg]; // RULE12
        pend_reg[ch_reg] <= 1'b1; // RULE14
      end
    end
  end
  assign tx_irq = pend_reg; // RULE16
  // ************************************************************
  // state view of one channel
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    tx_queue_head_ptr <= rst ? `UTXQ_PTR_RST : head_reg[view_ch];
    tx_sop_descriptor_ptr <= rst ? `UTXQ_PTR_RST : sop_reg[view_ch];
    tx_current_descriptor_ptr <= rst ? `UTXQ_PTR_RST : cur_reg[view_ch];
    tx_current_buffer_ptr <= rst ? `UTXQ_PTR_RST : buf_reg[view_ch];
    tx_scratch_word <= rst ? `UTXQ_PTR_RST : scr_reg[view_ch];
    tx_packet_length_state <= rst ? `UTXQ_PTR_RST : {rem_reg[view_ch], act_reg[view_ch]};
    tx_completion_ptr <= rst ? `UTXQ_PTR_RST : comp_reg[view_ch];
  end
  // ************************************************************
  // endpoint data path
  // ************************************************************
  // last byte when the packet length runs out or the final buffer empties
  utxq_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(state_reg == UTXQ_PUSH),
    .in_ready(fifo_in_ready),
    .in_data({ch_reg, (rem_reg[ch_reg] == 16'h0001) ||
              (flags_reg[`UTXQ_LAST_BUF_BIT] && bcnt_reg == 16'h0001), byte_reg}),
    .out_valid(ep_valid),
    .out_ready(ep_ready),
    .out_data(fifo_out)
  );
  assign ep_data = fifo_out[7:0];
  assign ep_last = fifo_out[8];
  assign ep_ch = fifo_out[FW-1:9];
endmodule : utxq_dma

// file: utxq_map.svh
// utxq_map.svh: descriptor layout, state word selects and reset values of the tx queue dma
`ifndef UTXQ_MAP_SVH
`define UTXQ_MAP_SVH

// ************************************************************
// descriptor word byte offsets
// ************************************************************
`define UTXQ_DESC_NEXT_OFS 32'h0000_0000
`define UTXQ_DESC_BUF_OFS 32'h0000_0004
`define UTXQ_DESC_LEN_OFS 32'h0000_0008
`define UTXQ_DESC_FLAGS_OFS 32'h0000_000C

// ************************************************************
// word 3 flag positions and word 2 / word 3 fields
// ************************************************************
`define UTXQ_FIRST_BUF_BIT 31
`define UTXQ_LAST_BUF_BIT 30
`define UTXQ_OWN_BIT 29
`define UTXQ_QUEUE_END_BIT 28
`define UTXQ_ZERO_BYTE_BIT 23
`define UTXQ_LEN_MSB 15
`define UTXQ_OFS_LSB 16

// ************************************************************
// software state word selects
// ************************************************************
`define UTXQ_SEL_HEAD 3'h0
`define UTXQ_SEL_SOP 3'h1
`define UTXQ_SEL_CUR 3'h2
`define UTXQ_SEL_BUF 3'h3
`define UTXQ_SEL_SCRATCH 3'h4
`define UTXQ_SEL_LEN 3'h5
`define UTXQ_SEL_COMP 3'h6

// ************************************************************
// pointer reset value and default fifo depth
// ************************************************************
`define UTXQ_PTR_RST 32'h0000_0000
`define UTXQ_FIFO_DEPTH 32

`endif

// file: utxq_pkg.sv
// utxq_pkg.sv: types shared by the tx queue dma files
package utxq_pkg;

  // engine sequencer states
  typedef enum logic [3:0] {
    UTXQ_IDLE = 4'b0000,
    UTXQ_RD_NEXT = 4'b0001,
    UTXQ_RD_BUF = 4'b0010,
    UTXQ_RD_LEN = 4'b0011,
    UTXQ_RD_FLAGS = 4'b0100,
    UTXQ_CHK = 4'b0101,
    UTXQ_RD_BYTE = 4'b0110,
    UTXQ_PUSH = 4'b0111,
    UTXQ_WR_EOQ = 4'b1000,
    UTXQ_WR_OWN = 4'b1001,
    UTXQ_COMP = 4'b1010
  } utxq_state_t;

endpackage : utxq_pkg

// file: utxq_fifo.sv
// utxq_fifo.sv: flip-flop fifo with valid/ready on both sides
module utxq_fifo
  import utxq_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("utxq_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic do_wr;
  logic do_rd;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

  // storage, no reset needed: empty flag guards the contents
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : utxq_fifo

// file: utxq_dma_assertions.sv
// utxq_dma_assertions.sv: port-level checker for the tx queue dma engine
module utxq_dma_checker
  import utxq_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sw_wr,
  input wire logic [$clog2(NUM_CH)-1:0] sw_ch,
  input wire logic [2:0] sw_sel,
  input wire logic [31:0] sw_data,
  input wire logic [$clog2(NUM_CH)-1:0] view_ch,
  input wire logic [31:0] tx_queue_head_ptr,
  input wire logic [31:0] tx_completion_ptr,
  input wire logic [NUM_CH-1:0] tx_irq,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic ep_valid,
  input wire logic ep_ready,
  input wire logic [7:0] ep_data,
  input wire logic ep_last,
  input wire logic [$clog2(NUM_CH)-1:0] ep_ch
);
  // ************************************************************
  // helper: cycles since the last owner release write
  // ************************************************************
  logic [3:0] own_age_reg;
  logic own_wr;

  // an interrupt edge far from an owner release would be spurious
  assign own_wr = mem_req && mem_we && mem_ack && !mem_wdata[29] && mem_wdata[31];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      own_age_reg <= 4'hf;
    end else if (own_wr) begin
      own_age_reg <= 4'h0;
    end else if (own_age_reg != 4'hf) begin
      own_age_reg <= own_age_reg + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request moved before ack");
  a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("memory access not word aligned");
  a_reset_quiet: assert property ($fell(rst) |-> !mem_req && !ep_valid && tx_irq == '0)
    else $error("activity right after reset");
  a_eoq_then_own: assert property (mem_req && mem_we && mem_ack && mem_wdata[28]
    && mem_wdata[29] |-> ##[1:6] (mem_req && mem_we && !mem_wdata[29] && mem_wdata[31]))
    else $error("no owner release after queue end write");
  a_irq_follows_own: assert property (own_wr |-> ##[1:3] tx_irq != '0)
    else $error("no interrupt after owner release");
  a_irq_cause: assert property ((tx_irq & ~$past(tx_irq)) != '0 |-> own_age_reg <= 4'd3)
    else $error("interrupt rose without a completed packet");
  a_irq_drop_cause: assert property (!$past(rst) && (~tx_irq & $past(tx_irq)) != '0
    |-> $past(sw_wr) && $past(sw_sel) == 3'h6) else $error("interrupt fell without ack");
  a_irq_wrong_ack: assert property (sw_wr && sw_sel == 3'h6 && sw_ch == view_ch
    && $stable(view_ch) && sw_data != tx_completion_ptr && tx_irq[sw_ch]
    |=> tx_irq[$past(sw_ch)]) else $error("wrong ack cleared interrupt");
  a_irq_ack_clears: assert property (sw_wr && sw_sel == 3'h6 && sw_ch == view_ch
    && $stable(view_ch) && sw_data == tx_completion_ptr && tx_irq[sw_ch]
    && own_age_reg >= 4'd3 |=> !tx_irq[$past(sw_ch)]) else $error("matching ack kept interrupt");
  a_ep_hold: assert property (ep_valid && !ep_ready |=> ep_valid && $stable(ep_data)
    && $stable(ep_last) && $stable(ep_ch)) else $error("endpoint word dropped while stalled");
  a_head_write: assert property (sw_wr && sw_sel == 3'h0 && sw_ch == view_ch ##1
    $stable(view_ch) |=> tx_queue_head_ptr == $past(sw_data, 2)) else $error("head write lost");
endmodule : utxq_dma_checker

bind utxq_dma utxq_dma_checker #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) u_checker (
  .ref_clk, .rst, .sw_wr, .sw_ch, .sw_sel, .sw_data, .view_ch, .tx_queue_head_ptr,
  .tx_completion_ptr, .tx_irq, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .ep_valid, .ep_ready, .ep_data, .ep_last, .ep_ch
);

// file: utxq_mem_model.sv
// utxq_mem_model.sv: processor memory holding descriptors and buffers
module utxq_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words [int unsigned];
  int wait_cnt;
  logic go;

  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0000_0000;
  assign go = !rst && mem_req && !mem_ack;
  // answer after one or four cycles; read data toggles outside ack so stale use shows
  always @(posedge ref_clk) begin
    if (go && wait_cnt >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      wait_cnt <= 0;
      if (mem_we) words[mem_addr[31:2]] = mem_wdata;
      mem_rdata <= words.exists(mem_addr[31:2]) ? words[mem_addr[31:2]] : 32'h0000_0000;
    end else begin
      mem_ack <= 1'b0;
      wait_cnt <= go ? wait_cnt + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : utxq_mem_model

// file: utxq_dma_bench.sv
// utxq_dma_bench.sv: self-checking bench for the tx queue dma engine
module utxq_dma_bench
  import utxq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, dma_port_enable, sw_wr, ep_ready, slow, stall;
  logic mem_req, mem_we, mem_ack, ep_valid, ep_last;
  logic [3:0] endpoint_dma_enable, tx_irq;
  logic [1:0] sw_ch, view_ch, ep_ch;
  logic [2:0] sw_sel;
  logic [7:0] ep_data;
  logic [31:0] sw_data, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] view [7];
  logic [10:0] exp_q [$];
  int fails, checks, seed;

  utxq_dma #(.NUM_CH(4), .FIFO_DEPTH(32)) dut (
    .ref_clk, .rst, .dma_port_enable, .endpoint_dma_enable, .sw_wr, .sw_ch, .sw_sel, .sw_data,
    .view_ch, .tx_queue_head_ptr(view[0]), .tx_sop_descriptor_ptr(view[1]),
    .tx_current_descriptor_ptr(view[2]), .tx_current_buffer_ptr(view[3]),
    .tx_scratch_word(view[4]), .tx_packet_length_state(view[5]), .tx_completion_ptr(view[6]),
    .tx_irq, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ep_valid,
    .ep_ready, .ep_data, .ep_last, .ep_ch
  );
  utxq_mem_model u_mem (
    .ref_clk, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // one strobe cycle, then two edges so the registered view has caught up
  task automatic sw_write(input logic [2:0] sel, input logic [31:0] data);
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_ch <= 2'd1;
    sw_sel <= sel;
    sw_data <= data;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : sw_write

  task automatic wait_irq();
    int n;
    n = 0;
    while (tx_irq[1] !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    #1;
    check("irq wait", 32'h1, {31'h0, tx_irq[1]});
    if (n == 4000) summarize();
  endtask : wait_irq

  task automatic drain();
    int n;
    for (n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge ref_clk);
    check("bytes drained", 32'h0, exp_q.size());
    if (exp_q.size() != 0) summarize();
  endtask : drain

  task automatic put_desc(input logic [31:0] a, nxt, bp, w2, w3);
    u_mem.words[a >> 2] = nxt;
    u_mem.words[(a >> 2) + 1] = bp;
    u_mem.words[(a >> 2) + 2] = w2;
    u_mem.words[(a >> 2) + 3] = w3;
  endtask : put_desc

  // owner and queue end flags of a descriptor
  function automatic logic [1:0] w3_of(input logic [31:0] a);
    return u_mem.words[(a >> 2) + 3][29:28];
  endfunction : w3_of

  // little endian byte lanes of the buffer words
  task automatic expect_bytes(input logic [31:0] a, input int n, input logic last);
    logic [31:0] w;
    for (int i = 0; i < n; i++) begin
      w = u_mem.words[(a + i) >> 2];
      exp_q.push_back({2'd1, last && i == n - 1, w[8 * ((a + i) % 4) +: 8]});
    end
  endtask : expect_bytes

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // endpoint side: random readiness, or a hard stall to fill the fifo
  always @(posedge ref_clk) ep_ready <= !stall && ($random(seed) % 3 != 0);

  // compare every accepted endpoint word with the oldest expected one
  always @(posedge ref_clk) begin
    if (!rst && ep_valid === 1'b1 && ep_ready === 1'b1) begin
      check("byte expected", 32'h1, {31'h0, exp_q.size() != 0});
      if (exp_q.size() != 0) check("endpoint word", {21'h0, exp_q.pop_front()},
        {21'h0, ep_ch, ep_last, ep_data});
    end
  end

  initial begin
    seed = 32'h3902;
    {rst, dma_port_enable, sw_wr, slow, stall, ep_ready} = 6'b100000;
    {endpoint_dma_enable, sw_ch, sw_sel, sw_data} = '0;
    view_ch = 2'd1;
    for (int i = 0; i < 128; i++) u_mem.words[32'h400 + i] = $random(seed);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("irq after reset", 32'h0, {28'h0, tx_irq});
    for (int s = 0; s < 7; s++) check("state after reset", 32'h0, view[s]);
    for (int s = 1; s < 6; s++) begin
      sw_write(3'(s), 32'h0A50_0000 + s);
      check("state word", 32'h0A50_0000 + s, view[s]);
      sw_write(3'(s), 32'h0000_0000);
      check("state zeroed", 32'h0, view[s]);
    end
    $display("test state words done");
    put_desc(32'h100, 32'h110, 32'h1001, 32'h0000_0002, 32'hA000_0003);
    put_desc(32'h110, 32'h120, 32'h1042, 32'h0000_0001, 32'h4000_0000);
    put_desc(32'h120, 32'h0, 32'h1083, 32'h0001_0004, 32'hE000_0002);
    expect_bytes(32'h1001, 2, 1'b0);
    expect_bytes(32'h1042, 1, 1'b1);
    expect_bytes(32'h1084, 2, 1'b1);
    @(posedge ref_clk);
    slow <= 1'b1;
    endpoint_dma_enable <= 4'b0010;
    dma_port_enable <= 1'b1;
    sw_write(3'h0, 32'h100);
    wait_irq();
    check("first completion", 32'h110, view[6]);
    check("first owner", 32'h0, {30'h0, w3_of(32'h100)});
    check("next owned", 32'h2, {30'h0, w3_of(32'h120)});
    sw_write(3'h6, 32'h120);
    check("irq on wrong ack", 32'h1, {31'h0, tx_irq[1]});
    sw_write(3'h6, 32'h110);
    check("irq on ack", 32'h0, {31'h0, tx_irq[1]});
    wait_irq();
    check("last completion", 32'h120, view[6]);
    check("head at queue end", 32'h0, view[0]);
    check("queue end flags", 32'h1, {30'h0, w3_of(32'h120)});
    sw_write(3'h6, 32'h120);
    check("irq after last ack", 32'h0, {31'h0, tx_irq[1]});
    drain();
    $display("test two packets done");
    u_mem.words[32'h120 >> 2] = 32'h200;
    put_desc(32'h200, 32'h0, 32'h1100, 32'h0000_0028, 32'hE000_0028);
    expect_bytes(32'h1100, 40, 1'b1);
    @(posedge ref_clk);
    stall <= 1'b1;
    sw_write(3'h0, 32'h200);
    repeat (300) @(posedge ref_clk);
    check("bytes held in stall", 32'd40, exp_q.size());
    check("fifo valid in stall", 32'h1, {31'h0, ep_valid});
    stall <= 1'b0;
    wait_irq();
    check("restart completion", 32'h200, view[6]);
    sw_write(3'h6, 32'h200);
    drain();
    $display("test restart and stall done");
    summarize();
  end
endmodule : utxq_dma_bench
